// file: design/aivs_flag.sv
// one sticky event flag: hardware set beats software clear
`timescale 1ns/100ps
module aivs_flag (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic set,
    input wire logic clr,
    input wire logic wr_one,
    output logic q
);
    logic q_r;
    logic q_nxt;
    assign q_nxt = set | wr_one | (q_r & ~clr);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end
    assign q = q_r;
endmodule

// file: design/aivs_top.sv
// converter interrupt vector select with AXI4-Lite register slave
`timescale 1ns/100ps
module aivs_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic group_done,
    input wire logic window_exit,
    input wire logic irq_ack,
    output logic irq_req,
    output logic [aivs_pkg::AIVS_PRIO_W-1:0] irq_priority_level,
    output logic [7:0] irq_vector,
    output logic irq,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import aivs_pkg::*;

    // ------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    wire aw_take = s_axi_awvalid & ~aw_held_r & ~bvalid_r;
    wire w_take = s_axi_wvalid & ~w_held_r & ~bvalid_r;
    wire wr_go = aw_held_r & w_held_r;
    wire wr_ctrl = wr_go & wstrb0_r & (awaddr_r == AIVS_ADDR_CTRL);
    wire wr_vec = wr_go & wstrb0_r & (awaddr_r == AIVS_ADDR_VECTOR);
    wire wr_mask = wr_go & wstrb0_r & (awaddr_r == AIVS_ADDR_MASK);
    wire wr_hit = (awaddr_r == AIVS_ADDR_CTRL) |
        (awaddr_r == AIVS_ADDR_VECTOR) | (awaddr_r == AIVS_ADDR_MASK) |
        (awaddr_r == AIVS_ADDR_STATUS);
    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= AIVS_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? AIVS_RESP_OKAY : AIVS_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control, vector base and flags
    // ------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic [5:0] base_r;
    logic cd_flag;
    logic wa_flag;
    logic cd_clr;
    logic wa_clr;
    assign cd_clr = wr_ctrl & ~wdata_r[AIVS_CTRL_CDF];
    assign wa_clr = wr_ctrl & ~wdata_r[AIVS_CTRL_WAF];

    aivs_flag u_conversion_done_flag (
        .clk(clk),
        .rst_b(rst_b),
        .set(group_done),
        .clr(cd_clr),
        .wr_one(wr_ctrl & wdata_r[AIVS_CTRL_CDF]),
        .q(cd_flag)
    );
    aivs_flag u_window_alarm_flag (
        .clk(clk),
        .rst_b(rst_b),
        .set(window_exit),
        .clr(wa_clr),
        .wr_one(wr_ctrl & wdata_r[AIVS_CTRL_WAF]),
        .q(wa_flag)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= AIVS_CTRL_RST[5:4];
            base_r <= AIVS_BASE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= wdata_r[5:4];
            end
            if (wr_vec) begin
                base_r <= wdata_r[7:2];
            end
        end
    end
    wire conversion_done_irq_en = ctrl_r[1];
    wire window_alarm_irq_en = ctrl_r[0];
    logic [AIVS_PRIO_W-1:0] prio_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prio_r <= AIVS_CTRL_RST[2:0];
        end else if (wr_ctrl) begin
            prio_r <= wdata_r[2:0];
        end
    end
    assign irq_priority_level = prio_r;

    // ------------------------------------------------------------
    // source arbitration and vector
    // ------------------------------------------------------------
    wire wa_req = wa_flag & window_alarm_irq_en;
    wire cd_req = cd_flag & conversion_done_irq_en;
    // watchdog wins; conversion stays pending in its flag meanwhile
    wire ws_nxt = ~wa_req & cd_req;
    logic ws_r;
    logic [7:0] vec_out_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ws_r <= AIVS_VEC_RST[AIVS_VEC_WS];
            vec_out_r <= 8'h00;
        end else begin
            if (wa_req || cd_req) begin
                ws_r <= ws_nxt;
            end
            if (irq_ack) begin
                vec_out_r <= {base_r, ws_nxt, 1'b0};
            end
        end
    end
    assign irq_req = wa_req | cd_req;
    assign irq_vector = vec_out_r;
    wire [7:0] vec_rd = {base_r, ws_r, 1'b0};

    // ------------------------------------------------------------
    // sticky interrupt status, cleared by read
    // ------------------------------------------------------------
    logic [2:0] st_r;
    logic [2:0] mask_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    wire ar_take = s_axi_arvalid & ~rvalid_r;
    wire [11:0] ar_a = {s_axi_araddr[11:2], 2'h0};
    wire rd_st = ar_take & (ar_a == AIVS_ADDR_STATUS);
    wire [2:0] ev = {window_exit & group_done, window_exit, group_done};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= 3'h0;
            mask_r <= 3'h0;
        end else begin
            // new events beat the read clear
            st_r <= (rd_st ? 3'h0 : st_r) | ev;
            if (wr_mask) begin
                mask_r <= wdata_r[2:0];
            end
        end
    end
    assign irq = |(st_r & mask_r);

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    // reserved bit 3 is not stored; it reads back its value after reset
    wire [7:0] ctrl_rd = {cd_flag, wa_flag, ctrl_r, AIVS_CTRL_RST[3], prio_r};
    wire ar_hit = (ar_a == AIVS_ADDR_CTRL) | (ar_a == AIVS_ADDR_VECTOR) |
        (ar_a == AIVS_ADDR_STATUS) | (ar_a == AIVS_ADDR_MASK);
    wire [31:0] rd_mux =
        (ar_a == AIVS_ADDR_CTRL) ? {24'h000000, ctrl_rd} :
        (ar_a == AIVS_ADDR_VECTOR) ? {24'h000000, vec_rd} :
        (ar_a == AIVS_ADDR_STATUS) ? {29'h00000000, st_r} :
        (ar_a == AIVS_ADDR_MASK) ? {29'h00000000, mask_r} : 32'h0000_0000;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= AIVS_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= ar_hit ? AIVS_RESP_OKAY : AIVS_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence both_raised_s;
        wa_req && cd_req;
    endsequence
    property wdog_first_p;
        @(posedge clk) disable iff (!rst_b)
        both_raised_s ##0 irq_ack |=> irq_vector[1] == 1'b0;
    endproperty
    wdog_priority_a: assert property (wdog_first_p)
        else $error("watchdog did not win arbitration");
    conv_upper_a: assert property (@(posedge clk) disable iff (!rst_b)
        (irq_ack && cd_req && !wa_req) |=> irq_vector[1])
        else $error("conversion vector not upper word");
    wdog_lower_a: assert property (@(posedge clk) disable iff (!rst_b)
        (irq_ack && wa_req) |=> !irq_vector[1])
        else $error("watchdog vector not lower word");
    bit_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        irq_ack |=> irq_vector[0] == 1'b0 && vec_rd[0] == 1'b0)
        else $error("reserved bit not zero");
    base_store_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_vec |=> base_r == $past(wdata_r[7:2]))
        else $error("vector base not stored");
    conv_pending_a: assert property (@(posedge clk) disable iff (!rst_b)
        (cd_flag && !cd_clr) |=> cd_flag)
        else $error("pending conversion lost");
    done_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        group_done |=> cd_flag)
        else $error("conversion flag not set");
    alarm_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        window_exit |=> wa_flag)
        else $error("alarm flag not set");
    mask_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
        irq_req |-> (cd_flag && conversion_done_irq_en) ||
            (wa_flag && window_alarm_irq_en))
        else $error("masked source raised request");
    prio_out_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_ctrl |=> irq_priority_level == $past(wdata_r[2:0]))
        else $error("priority level not presented");
    reset_low_a: assert property (@(posedge clk)
        $rose(rst_b) |-> vec_rd[1:0] == 2'b10)
        else $error("vector low bits not 10 after reset");
endmodule

// file: inc/aivs_pkg.sv
// register map, field layout and constants of the converter vector select
package aivs_pkg;
    // register byte addresses; the vector register sits at four times its index
    localparam logic [7:0] AIVS_IDX_VECTOR = 8'hFF;
    localparam logic [11:0] AIVS_ADDR_VECTOR = {2'h0, AIVS_IDX_VECTOR, 2'h0};
    localparam logic [11:0] AIVS_ADDR_CTRL = 12'h000;
    localparam logic [11:0] AIVS_ADDR_STATUS = 12'h004;
    localparam logic [11:0] AIVS_ADDR_MASK = 12'h008;
    // control register fields
    localparam int AIVS_CTRL_CDF = 7;
    localparam int AIVS_CTRL_WAF = 6;
    localparam int AIVS_CTRL_CDE = 5;
    localparam int AIVS_CTRL_WAE = 4;
    localparam int AIVS_PRIO_W = 3;
    localparam logic [7:0] AIVS_CTRL_RST = 8'h0F;
    // vector register fields
    localparam int AIVS_VEC_WS = 1;
    localparam logic [7:0] AIVS_VEC_RST = 8'h02;
    localparam logic [5:0] AIVS_BASE_RST = 6'h00;
    // interrupt status bits
    localparam int AIVS_ST_CD = 0;
    localparam int AIVS_ST_WA = 1;
    localparam int AIVS_ST_W = 2;
    localparam logic [1:0] AIVS_RESP_OKAY = 2'h0;
    localparam logic [1:0] AIVS_RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        AIVS_IDLE = 3'h1,
        AIVS_WA_PEND = 3'h2,
        AIVS_CD_PEND = 3'h4
    } aivs_src_type;
endpackage

// file: verification/adc_interrupt_vector_select_tb.sv
// self-checking bench of the converter vector select
`timescale 1ns/100ps
module adc_interrupt_vector_select_tb;
    import aivs_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, group_done = 1'b0, window_exit = 1'b0;
    logic irq_ack, irq_req, irq, got, en = 1'b0;
    logic [2:0] irq_priority_level;
    logic [7:0] irq_vector, vec;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    int fail_count = 0, n_compared = 0;
    always #10 clk = ~clk;
    aivs_top aivs_top_i (.clk, .rst_b, .group_done, .window_exit, .irq_ack,
        .irq_req, .irq_priority_level, .irq_vector, .irq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    aivs_cpu_model aivs_cpu_model_i (.clk, .rst_b, .en, .irq_req,
        .irq_vector, .irq_ack, .got, .vec);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask
    task automatic hang;
        fail_count++;
        tally_and_finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
    endtask
    task automatic rdr(input logic [11:0] a);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
    endtask
    task automatic settle;
        @(posedge clk);
        #1;
    endtask
    task automatic fetch(input logic [7:0] exp);
        int n;
        en <= 1'b1;
        for (n = 0; n < 20 && got !== 1'b1; n++) settle();
        if (n == 20) hang();
        chk("irq_vector", vec, exp);
        en <= 1'b0;
        repeat (4) settle();
    endtask
    task automatic t_reset;
        rdr(AIVS_ADDR_VECTOR);
        chk("vector after reset", rd[1:0], 2'h2);
        rdr(AIVS_ADDR_CTRL);
        chk("ctrl after reset", rd, 32'h0F);
        chk("priority after reset", irq_priority_level, 3'h7);
    endtask
    task automatic t_base;
        wr(AIVS_ADDR_VECTOR, 8'hFF);
        chk("write resp", rs, AIVS_RESP_OKAY);
        rdr(AIVS_ADDR_VECTOR);
        chk("read resp", rs, AIVS_RESP_OKAY);
        chk("vector base", rd, 32'hFE);
        chk("reserved bit", rd[0], 1'b0);
    endtask
    task automatic t_both;
        wr(AIVS_ADDR_MASK, 8'h07);
        wr(AIVS_ADDR_CTRL, 8'h35);
        chk("priority", irq_priority_level, 3'h5);
        @(posedge clk);
        window_exit <= 1'b1;
        group_done <= 1'b1;
        @(posedge clk);
        window_exit <= 1'b0;
        group_done <= 1'b0;
        settle();
        chk("irq level", irq, 1'b1);
        fetch(8'hFC);
        // alarm serviced; conversion must still be pending
        wr(AIVS_ADDR_CTRL, 8'hB5);
        fetch(8'hFE);
        rdr(AIVS_ADDR_VECTOR);
        chk("word select readback", rd, 32'hFE);
        rdr(AIVS_ADDR_STATUS);
        chk("status", rd, 32'h7);
        settle();
        chk("irq after read", irq, 1'b0);
        rdr(AIVS_ADDR_STATUS);
        chk("status cleared", rd, 32'h0);
    endtask
    task automatic t_mask;
        logic [7:0] c[6] = '{8'h85, 8'hA5, 8'h45, 8'h55, 8'h05, 8'h15};
        logic e[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 6; i++) begin
            wr(AIVS_ADDR_CTRL, c[i]);
            settle();
            chk("irq_req", irq_req, e[i]);
        end
    endtask
    task automatic t_unmapped;
        rdr(12'h010);
        chk("unmapped read resp", rs, AIVS_RESP_SLVERR);
        chk("unmapped read data", rd, 32'h0);
        wr(12'h010, 8'hAA);
        chk("unmapped write resp", rs, AIVS_RESP_SLVERR);
    endtask
    task automatic t_rereset;
        // last request raised was the alarm (in t_mask), so word select is low here
        rdr(AIVS_ADDR_VECTOR);
        chk("word select alarm", rd, 32'hFC);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdr(AIVS_ADDR_VECTOR);
        chk("vector after rereset", rd, {24'h0, AIVS_VEC_RST});
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_base();
        t_both();
        t_mask();
        t_unmapped();
        t_rereset();
        tally_and_finish();
    end
endmodule

// file: verification/aivs_cpu_model.sv
// cpu-side interrupt handler model: acknowledges and fetches the vector
`timescale 1ns/100ps
module aivs_cpu_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    input wire logic irq_req,
    input wire logic [7:0] irq_vector,
    output logic irq_ack,
    output logic got,
    output logic [7:0] vec
);
    logic wait_r;
    // one ack in flight at a time, so a vector is never fetched stale
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ack <= 1'b0;
            wait_r <= 1'b0;
            got <= 1'b0;
            vec <= 8'h00;
        end else begin
            irq_ack <= en & irq_req & ~irq_ack & ~wait_r;
            wait_r <= irq_ack;
            got <= wait_r;
            if (wait_r) begin
                vec <= irq_vector;
            end
        end
    end
endmodule
